/* File: t2rc_pkg.sv */
package t2rc_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CONTROL = 8'hc8;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
   localparam logic [7:0] ADDR_OUTPUT_CTRL = 8'ha6;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hd0;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'hd1;
   // ------------------------------------------------------------
   // Control register bit positions
   // ------------------------------------------------------------
   localparam int BIT_OVF = 7;
   localparam int BIT_EXTF = 6;
   localparam int BIT_RXCLK = 5;
   localparam int BIT_TXCLK = 4;
   localparam int BIT_EXTEN = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_CT = 1;
   localparam int BIT_CAP = 0;
   // Output control fields
   localparam int BIT_INSEL = 7;
   localparam int DUTY_LSB = 3;
   localparam int DUTY_MSB = 5;
   // Interrupt status bits
   localparam int IRQ_OVF = 0;
   localparam int IRQ_EXT = 1;
   localparam int IRQ_BITS = 2;
   // Reset values and misc
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] PIN_MODE_WAVE = 2'h3;
   localparam int SLOW_DIV = 16;
   localparam int TIMER_PRESCALE = 2;
   // Duty field codes
   localparam logic [2:0] DUTY_HALF = 3'h0;
   localparam logic [2:0] DUTY_THIRD = 3'h1;
   localparam logic [2:0] DUTY_QUARTER = 3'h2;
   localparam logic [2:0] DUTY_TWO_THIRDS = 3'h5;
   localparam logic [2:0] DUTY_THREE_QUARTERS = 3'h6;
endpackage

/* File: t2rc_wave.sv */
module t2rc_wave
   import t2rc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Overflow events and duty code
   input wire logic ovfPulse,
   input wire logic [2:0] dutyCode,
   // Waveform
   output logic waveLevel
);
   logic [1:0] phase;
   logic [1:0] period;
   logic [1:0] highPhases;

   // ------------------------------------------------------------
   // Decode of the duty field
   // ------------------------------------------------------------
   // Unlisted codes fall back to half duty so the pin never sticks
   always_comb begin
      case (dutyCode)
         DUTY_THIRD: begin
            period = 2'h2;
            highPhases = 2'h1;
         end
         DUTY_QUARTER: begin
            period = 2'h3;
            highPhases = 2'h1;
         end
         DUTY_TWO_THIRDS: begin
            period = 2'h2;
            highPhases = 2'h2;
         end
         DUTY_THREE_QUARTERS: begin
            period = 2'h3;
            highPhases = 2'h3;
         end
         default: begin
            period = 2'h1;
            highPhases = 2'h1;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Phase counter stepped by overflow
   // ------------------------------------------------------------
   // phase per overflow
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         phase <= 2'h0;
      end else if (ovfPulse) begin
         if (phase >= period) begin
            phase <= 2'h0;
         end else begin
            phase <= phase + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         waveLevel <= 1'b0;
      end else begin
         waveLevel <= (phase < highPhases);
      end
   end
endmodule

/* File: t2rc_timer.sv */
module t2rc_timer
   import t2rc_pkg::*;
#(
   parameter int COUNT_WIDTH = 16
)(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Register port
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   // External pins and clocks
   input wire logic countPin,
   input wire logic triggerPin,
   input wire logic slowClock,
   input wire logic [1:0] portPinMode,
   // Waveform pin
   output logic wavePinOut,
   output logic wavePinOe,
   // UART baud clocks
   output logic uartTxBaud,
   output logic uartRxBaud,
   // Interrupt
   output logic irq
);
   logic [7:0] control;
   logic [7:0] outCtrl;
   logic [COUNT_WIDTH-1:0] count;
   logic [COUNT_WIDTH-1:0] reload;
   logic [IRQ_BITS-1:0] irqStatus;
   logic [IRQ_BITS-1:0] irqMask;
   logic countPrev, trigPrev, slowPrev;
   logic [3:0] slowDiv;
   logic slowTick;
   logic halfTick;
   logic waveLevel;
   logic incEvent, trigEdge, ovf, baudMode, doReload, doCapture;
   logic [COUNT_WIDTH-1:0] next_count;

   // ------------------------------------------------------------
   // Edge detection on the synchronous pin inputs
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         countPrev <= 1'b0;
         trigPrev <= 1'b0;
         slowPrev <= 1'b0;
      end else begin
         countPrev <= countPin;
         trigPrev <= triggerPin;
         slowPrev <= slowClock;
      end
   end

   // Slow clock divided by 16; valid only if core clock is fast enough
   // sampling assumption
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         slowDiv <= 4'h0;
      end else if (slowPrev && !slowClock) begin
         slowDiv <= slowDiv + 4'h1;
      end
   end
   assign slowTick = slowPrev && !slowClock &&
      (slowDiv == 4'(SLOW_DIV - 1));

   // Divide-by-two enable for timer mode
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         halfTick <= 1'b0;
      end else begin
         halfTick <= !halfTick;
      end
   end

   // ------------------------------------------------------------
   // Count event selection
   // ------------------------------------------------------------
   // run and source
   always_comb begin
      if (!control[BIT_RUN]) begin
         incEvent = 1'b0;
      end else if (!control[BIT_CT]) begin
         incEvent = halfTick;
      end else if (outCtrl[BIT_INSEL]) begin
         incEvent = slowTick;
      end else begin
         incEvent = countPrev && !countPin;
      end
   end

   assign baudMode = control[BIT_RXCLK] | control[BIT_TXCLK];
   assign trigEdge = control[BIT_EXTEN] && trigPrev && !triggerPin;
   assign ovf = incEvent && (count == {COUNT_WIDTH{1'b1}});
   assign doCapture = trigEdge && control[BIT_CAP] && !baudMode;
   assign doReload = ovf && (baudMode || !control[BIT_CAP]) ||
      trigEdge && !control[BIT_CAP] && !baudMode;

   // ------------------------------------------------------------
   // Running count
   // ------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (doReload) begin
         next_count = reload;
      end else if (incEvent) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         count <= '0;
      end else if (regWrite && regAddr == ADDR_COUNT_LOW) begin
         count <= {count[COUNT_WIDTH-1:8], regWdata};
      end else if (regWrite && regAddr == ADDR_COUNT_HIGH) begin
         count <= {regWdata, count[7:0]};
      end else begin
         count <= next_count;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reload <= '0;
      end else if (doCapture) begin
         reload <= count;
      end else if (regWrite && regAddr == ADDR_RELOAD_LOW) begin
         reload <= {reload[COUNT_WIDTH-1:8], regWdata};
      end else if (regWrite && regAddr == ADDR_RELOAD_HIGH) begin
         reload <= {regWdata, reload[7:0]};
      end
   end

   // ------------------------------------------------------------
   // Control register with hardware flags
   // ------------------------------------------------------------
   // Flag set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         control <= RESET_BYTE;
      end else begin
         if (regWrite && regAddr == ADDR_CONTROL) begin
            control <= regWdata;
         end
         if (ovf && !baudMode) begin
            control[BIT_OVF] <= 1'b1;
         end
         if (trigEdge && !baudMode) begin
            control[BIT_EXTF] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         outCtrl <= RESET_BYTE;
      end else if (regWrite && regAddr == ADDR_OUTPUT_CTRL) begin
         outCtrl <= regWdata;
      end
   end

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irqStatus <= '0;
      end else begin
         for (int i = 0; i < IRQ_BITS; i++) begin
            if ((i == IRQ_OVF && ovf && !baudMode) ||
                (i == IRQ_EXT && trigEdge && !baudMode)) begin
               irqStatus[i] <= 1'b1;
            end else if (regWrite && regAddr == ADDR_IRQ_STATUS &&
                         regWdata[i]) begin
               irqStatus[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irqMask <= '0;
      end else if (regWrite && regAddr == ADDR_IRQ_MASK) begin
         irqMask <= regWdata[IRQ_BITS-1:0];
      end
   end

   // Registered output lags the status bit by one cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStatus & irqMask);
      end
   end

   // ------------------------------------------------------------
   // Register read port
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         regRdata <= RESET_BYTE;
      end else if (regRead) begin
         case (regAddr)
            ADDR_CONTROL: regRdata <= control;
            ADDR_RELOAD_LOW: regRdata <= reload[7:0];
            ADDR_RELOAD_HIGH: regRdata <= reload[COUNT_WIDTH-1:8];
            ADDR_COUNT_LOW: regRdata <= count[7:0];
            ADDR_COUNT_HIGH: regRdata <= count[COUNT_WIDTH-1:8];
            ADDR_OUTPUT_CTRL: regRdata <= outCtrl;
            ADDR_IRQ_STATUS: regRdata <= {6'h00, irqStatus};
            ADDR_IRQ_MASK: regRdata <= {6'h00, irqMask};
            default: regRdata <= RESET_BYTE;
         endcase
      end else begin
         regRdata <= RESET_BYTE;
      end
   end

   // ------------------------------------------------------------
   // UART baud clocks and waveform pin
   // ------------------------------------------------------------
   // receive baud only when selected; else the other timer feeds UART
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         uartTxBaud <= 1'b0;
         uartRxBaud <= 1'b0;
      end else begin
         uartTxBaud <= ovf && control[BIT_TXCLK];
         uartRxBaud <= ovf && control[BIT_RXCLK];
      end
   end

   t2rc_wave u_wave (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .ovfPulse(ovf),
      .dutyCode(outCtrl[DUTY_MSB:DUTY_LSB]),
      .waveLevel(waveLevel)
   );

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wavePinOut <= 1'b0;
         wavePinOe <= 1'b0;
      end else begin
         wavePinOe <= (portPinMode == PIN_MODE_WAVE);
         wavePinOut <= (portPinMode == PIN_MODE_WAVE) && waveLevel;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_ovf_flag;
      @(posedge core_clk) disable iff (sys_rst)
         ovf && !baudMode |=> control[BIT_OVF];
   endproperty
   a_ovf_flag: assert property (p_ovf_flag)
      else $error("overflow flag not set");

   property p_no_flag_baud;
      @(posedge core_clk) disable iff (sys_rst)
         baudMode && !control[BIT_OVF] && !regWrite |=> !control[BIT_OVF];
   endproperty
   a_no_flag_baud: assert property (p_no_flag_baud)
      else $error("overflow flag set in baud mode");

   property p_ext_flag;
      @(posedge core_clk) disable iff (sys_rst)
         trigEdge && !baudMode |=> control[BIT_EXTF];
   endproperty
   a_ext_flag: assert property (p_ext_flag)
      else $error("external flag not set");

   property p_rx_baud;
      @(posedge core_clk) disable iff (sys_rst)
         !control[BIT_RXCLK] |=> !uartRxBaud;
   endproperty
   a_rx_baud: assert property (p_rx_baud)
      else $error("receive baud without select");

   property p_stop;
      @(posedge core_clk) disable iff (sys_rst)
         !control[BIT_RUN] && !regWrite && !trigEdge |=> $stable(count);
   endproperty
   a_stop: assert property (p_stop)
      else $error("count moved while stopped");

   property p_reload;
      @(posedge core_clk) disable iff (sys_rst)
         ovf && baudMode && !regWrite |=> count == $past(reload);
   endproperty
   a_reload: assert property (p_reload)
      else $error("no reload on overflow");

   property p_capture;
      @(posedge core_clk) disable iff (sys_rst)
         doCapture |=> reload == $past(count);
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture missed");

   property p_pin_gate;
      @(posedge core_clk) disable iff (sys_rst)
         portPinMode != PIN_MODE_WAVE |=> !wavePinOe && !wavePinOut;
   endproperty
   a_pin_gate: assert property (p_pin_gate)
      else $error("waveform outside mode 3");

   property p_irq;
      @(posedge core_clk) disable iff (sys_rst)
         |(irqStatus & irqMask) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");

   c_ovf: cover property (@(posedge core_clk) ovf);
   c_capture: cover property (@(posedge core_clk) doCapture);
   c_trig_reload: cover property (@(posedge core_clk)
      trigEdge && doReload);
   c_wave: cover property (@(posedge core_clk) wavePinOut);
endmodule

/* File: t2rc_pin_model.sv */
// ------------------------------------------------------------
// Pin model: count input, trigger input and slow clock
// ------------------------------------------------------------
module t2rc_pin_model (
   // Clock
   input wire logic core_clk,
   // Requests from the bench
   input wire logic cntGo,
   input wire logic trgGo,
   input wire logic slowEn,
   // Pins toward the timer
   output logic countPin,
   output logic triggerPin,
   output logic slowClock
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slowPhase;

   initial begin
      countPin = 1'b1;
      triggerPin = 1'b1;
      slowClock = 1'b1;
      slowPhase = 1'b0;
   end

   // One-cycle low pulse per request, idle high so no stray edge
   always @(posedge core_clk) begin
      countPin <= !cntGo;
      triggerPin <= !trgGo;
   end

   // slow clock bound
   // Slow clock is a quarter of core clock; holds when stopped
   always @(posedge core_clk) begin
      if (slowEn) begin
         slowPhase <= !slowPhase;
         if (slowPhase) begin
            slowClock <= !slowClock;
         end
      end
   end
endmodule

/* File: t2rc_tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import t2rc_pkg::*;

   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata;
   logic [1:0] portPinMode = 2'h0;
   logic cntGo = 1'b0, trgGo = 1'b0, slowEn = 1'b0;
   logic countPin, triggerPin, slowClock;
   logic wavePinOut, wavePinOe, uartTxBaud, uartRxBaud, irq;
   int error_cnt = 0;
   int num_checks = 0;
   int seed = 32'h058c9784;
   int mdl[4];
   logic [7:0] rv;

   t2rc_timer uut (.core_clk(core_clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
      .regRead(regRead), .regRdata(regRdata), .countPin(countPin),
      .triggerPin(triggerPin), .slowClock(slowClock),
      .portPinMode(portPinMode), .wavePinOut(wavePinOut),
      .wavePinOe(wavePinOe), .uartTxBaud(uartTxBaud),
      .uartRxBaud(uartRxBaud), .irq(irq));

   t2rc_pin_model pins (.core_clk(core_clk), .cntGo(cntGo),
      .trgGo(trgGo), .slowEn(slowEn), .countPin(countPin),
      .triggerPin(triggerPin), .slowClock(slowClock));

   // ------------------------------------------------------------
   // Clock and watchdog
   // ------------------------------------------------------------
   initial begin
      forever #20 core_clk = !core_clk;
   end

   // Whole run needs well under this many cycles
   initial begin
      repeat (30000) @(posedge core_clk);
      error_cnt++;
      test_done();
   end

   // ------------------------------------------------------------
   // Bus tasks and checks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp,
         input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge core_clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRead <= 1'b0;
      @(negedge core_clk);
      d = regRdata;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a,
         input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(nm, {8'h00, exp}, {8'h00, d});
   endtask

   // Plain select instead of a ref, so the request is a static variable
   task automatic pulse(input bit trg, input int n);
      repeat (n) begin
         @(posedge core_clk);
         if (trg) begin
            trgGo <= 1'b1;
         end else begin
            cntGo <= 1'b1;
         end
         @(posedge core_clk);
         trgGo <= 1'b0;
         cntGo <= 1'b0;
         repeat (3) @(posedge core_clk);
      end
   endtask

   // Waveform: 240 cycles span whole periods for every duty code
   task automatic meas(input logic [2:0] code, input logic [7:0] ctl,
         input int hiExp, input int riseExp, input int txExp,
         input int rxExp);
      int hi, rise, tx, rx;
      logic prev;
      wr(ADDR_OUTPUT_CTRL, {2'b00, code, 3'b000});
      wr(ADDR_CONTROL, ctl);
      repeat (24) @(posedge core_clk);
      @(negedge core_clk);
      hi = 0;
      rise = 0;
      tx = 0;
      rx = 0;
      prev = wavePinOut;
      repeat (240) begin
         @(negedge core_clk);
         hi += (wavePinOut === 1'b1);
         rise += (wavePinOut === 1'b1 && prev === 1'b0);
         tx += (uartTxBaud === 1'b1);
         rx += (uartRxBaud === 1'b1);
         prev = wavePinOut;
      end
      chk("wave high", 16'(hiExp), 16'(hi));
      chk("wave rises", 16'(riseExp), 16'(rise));
      chk("tx baud", 16'(txExp), 16'(tx));
      chk("rx baud", 16'(rxExp), 16'(rx));
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] addrs[4];
      logic [2:0] codes[5];
      int hiTab[5], divTab[5];
      addrs = '{ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH, ADDR_COUNT_LOW,
         ADDR_COUNT_HIGH};
      codes = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
      hiTab = '{120, 80, 60, 160, 180};
      divTab = '{2, 3, 4, 3, 4};
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values, unmapped place reads zero
      rdchk("control", ADDR_CONTROL, 8'h00);
      foreach (addrs[i]) rdchk("reg reset", addrs[i], 8'h00);
      rdchk("unmapped", 8'h00, 8'h00);
      chk("oe idle", 16'h0000, {15'h0, wavePinOe});
      // Random readback while stopped, kept in the model
      foreach (addrs[i]) begin
         mdl[i] = $random(seed) & 8'hff;
         wr(addrs[i], 8'(mdl[i]));
      end
      wr(8'h00, 8'h5a);
      foreach (addrs[i]) rdchk("readback", addrs[i], 8'(mdl[i]));
      // Capture on trigger edge, count stopped
      wr(ADDR_CONTROL, 8'h09);
      pulse(1'b1, 1);
      rdchk("cap low", ADDR_RELOAD_LOW, 8'(mdl[2]));
      rdchk("cap high", ADDR_RELOAD_HIGH, 8'(mdl[3]));
      rdchk("ext flag", ADDR_CONTROL, 8'h49);
      // Reload on trigger edge
      mdl[0] = $random(seed) & 8'hff;
      mdl[1] = $random(seed) & 8'hff;
      wr(ADDR_RELOAD_LOW, 8'(mdl[0]));
      wr(ADDR_RELOAD_HIGH, 8'(mdl[1]));
      wr(ADDR_CONTROL, 8'h08);
      pulse(1'b1, 1);
      rdchk("rld low", ADDR_COUNT_LOW, 8'(mdl[0]));
      rdchk("rld high", ADDR_COUNT_HIGH, 8'(mdl[1]));
      rdchk("ext sticky", ADDR_CONTROL, 8'h48);
      // Counter mode on the count pin
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, 8'h06);
      pulse(1'b0, 5);
      wr(ADDR_CONTROL, 8'h02);
      pulse(1'b0, 2);
      rdchk("pin count", ADDR_COUNT_LOW, 8'h05);
      // Counter mode on slow clock over sixteen
      wr(ADDR_OUTPUT_CTRL, 8'h80);
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_CONTROL, 8'h06);
      @(posedge core_clk);
      slowEn <= 1'b1;
      repeat (128) @(posedge core_clk);
      slowEn <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      rdchk("slow count", ADDR_COUNT_LOW, 8'h02);
      // Timer overflow with reload, flag, interrupt
      wr(ADDR_COUNT_LOW, 8'hfa);
      wr(ADDR_COUNT_HIGH, 8'hff);
      wr(ADDR_RELOAD_LOW, 8'h34);
      wr(ADDR_RELOAD_HIGH, 8'h12);
      wr(ADDR_CONTROL, 8'h04);
      repeat (30) @(posedge core_clk);
      // Flag must come from hardware, so read it before software stops
      rdchk("ovf flag", ADDR_CONTROL, 8'h84);
      wr(ADDR_CONTROL, 8'h80);
      rdchk("reloaded", ADDR_COUNT_HIGH, 8'h12);
      rd(ADDR_IRQ_STATUS, rv);
      chk("irq status", 16'h0001, {15'h0, rv[IRQ_OVF]});
      chk("irq masked", 16'h0000, {15'h0, irq});
      wr(ADDR_IRQ_MASK, 8'h01);
      repeat (2) @(posedge core_clk);
      chk("irq set", 16'h0001, {15'h0, irq});
      wr(ADDR_IRQ_STATUS, 8'h03);
      repeat (2) @(posedge core_clk);
      chk("irq clear", 16'h0000, {15'h0, irq});
      wr(ADDR_CONTROL, 8'h00);
      rdchk("flag clear", ADDR_CONTROL, 8'h00);
      // Waveform on the shared pin, baud mode, reload ffff
      portPinMode <= PIN_MODE_WAVE;
      wr(ADDR_RELOAD_LOW, 8'hff);
      wr(ADDR_RELOAD_HIGH, 8'hff);
      // Count starts at the top, else the first overflow is far away
      wr(ADDR_COUNT_LOW, 8'hff);
      wr(ADDR_COUNT_HIGH, 8'hff);
      chk("oe on", 16'h0001, {15'h0, wavePinOe});
      foreach (codes[i]) begin
         meas(codes[i], 8'h14, hiTab[i], 120 / divTab[i], 120, 0);
      end
      meas(3'h0, 8'h24, 120, 60, 0, 120);
      rdchk("no ovf baud", ADDR_CONTROL, 8'h24);
      wr(ADDR_CONTROL, 8'h00);
      portPinMode <= 2'h1;
      repeat (2) @(posedge core_clk);
      chk("oe off", 16'h0000, {15'h0, wavePinOe});
      test_done();
   end
endmodule
